// ===== hw/srlt_host.sv
// Host-side read latency controller: picks the row, latches the code,
// and paces mode and latency cycles on serial clock ticks.
// Assumes sck_tick is a one-cycle pulse per serial clock on clk.
`timescale 1ns/1ps
module srlt_host
  import srlt_pkg::*;
(
  input  wire logic       clk,          // 25 MHz system clock
  input  wire logic       sys_rst,      // Synchronous reset, active high
  input  wire logic [7:0] sck_mhz,      // Serial clock rate in MHz
  input  wire logic       sck_tick,     // One pulse per serial clock cycle
  input  wire logic       req_valid,    // Read request
  input  wire srlt_cmd_t  req_cmd,      // Read command kind
  output logic            req_ready,    // Idle, request may be taken
  output logic      [1:0] lat_code,     // Code to program in the flash
  output logic            mode_phase,   // Host drives mode bits
  output logic            lat_phase,    // Dummy latency cycles running
  output logic            data_start,   // Pulse: device drives data next
  output logic            refused       // Pulse: command not allowed
);

  typedef enum logic [1:0] {ST_IDLE, ST_MODE, ST_LAT} srlt_state_t;

  srlt_state_t state;          // Sequencer state
  srlt_row_t   row;            // Row for current rate
  logic  [1:0] code;           // Looked-up latency code
  logic  [7:0] mode_cyc;       // Looked-up mode count
  logic  [7:0] lat_cyc;        // Looked-up latency count
  logic        supported;      // Lookup result usable
  logic  [7:0] mode_left;      // Mode cycles still to send
  logic  [7:0] lat_left;       // Latency cycles still to wait
  logic        accept;         // Request taken this cycle

  srlt_row_lookup u_lookup (
    .sck_mhz   (sck_mhz),
    .cmd       (req_cmd),
    .row       (row),
    .code      (code),
    .mode_cyc  (mode_cyc),
    .lat_cyc   (lat_cyc),
    .supported (supported)
  );

  // Handshake is combinational from the state
  assign req_ready  = (state == ST_IDLE);
  assign accept     = req_valid && req_ready;
  assign mode_phase = (state == ST_MODE);
  assign lat_phase  = (state == ST_LAT);

  // Sequencer: mode cycles first, then latency cycles
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE: begin
          // insert listed cycles, skip mode if none; a zero latency count still waits 256 ticks
          if (accept && supported) begin
            state <= (mode_cyc == SRLT_CYC_0) ? ST_LAT : ST_MODE;
          end
        end
        ST_MODE: begin
          if (sck_tick && mode_left == 8'h01) state <= ST_LAT;
        end
        ST_LAT: begin
          if (sck_tick && lat_left == 8'h01) state <= ST_IDLE;
        end
      endcase
    end
  end

  // Cycle counters, loaded on an accepted and supported read
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mode_left <= 8'h00;
      lat_left  <= 8'h00;
    end else if (accept && supported) begin
      mode_left <= mode_cyc;
      lat_left  <= lat_cyc;
    end else if (sck_tick && state == ST_MODE) begin
      mode_left <= mode_left - 8'h01;
    end else if (sck_tick && state == ST_LAT) begin
      lat_left <= lat_left - 8'h01;
    end
  end

  // Latency code held until the next accepted and supported read
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lat_code <= SRLT_CODE_80;
    end else if (accept && supported) begin
      lat_code <= code;
    end
  end

  // One-cycle outcome pulses
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      data_start <= 1'b0;
      refused    <= 1'b0;
    end else begin
      data_start <= (state == ST_LAT) && sck_tick && (lat_left == 8'h01);
      refused    <= accept && !supported;
    end
  end

  // Helper: ticks spent and total expected, for checks only
  logic [8:0] tick_cnt;
  logic [8:0] tick_exp;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tick_cnt <= 9'h000;
      tick_exp <= 9'h000;
    end else if (accept && supported) begin
      tick_cnt <= 9'h000;
      tick_exp <= {1'b0, mode_cyc} + {1'b0, lat_cyc};
    end else if (sck_tick && state != ST_IDLE) begin
      tick_cnt <= tick_cnt + 9'h001;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  logic ok;
  assign ok = accept && supported;

  code_80_a: assert property (ok && sck_mhz <= 8'h50 |=> lat_code == 2'h0)
    else $error("wrong code up to 80 MHz");
  fast_80_a: assert property (ok && sck_mhz <= 8'h50 && req_cmd == SRLT_RD_FAST
    |=> lat_phase && lat_left == 8'h08)
    else $error("fast read at 80 MHz not 0+8");
  quad_io_80_a: assert property (ok && sck_mhz <= 8'h50 && req_cmd == SRLT_RD_QUAD_IO
    |=> mode_phase && mode_left == 8'h02 && lat_left == 8'h04)
    else $error("quad I/O at 80 MHz not 2+4");
  code_90_a: assert property (ok && sck_mhz > 8'h50 && sck_mhz <= 8'h5A
    |=> lat_code == 2'h1)
    else $error("wrong code up to 90 MHz");
  dual_io_90_a: assert property (ok && sck_mhz > 8'h50 && sck_mhz <= 8'h5A
    && req_cmd == SRLT_RD_DUAL_IO |=> lat_phase && lat_left == 8'h05)
    else $error("dual I/O at 90 MHz not 0+5");
  plain_refuse_a: assert property (accept && sck_mhz > 8'h50 && req_cmd == SRLT_RD_PLAIN
    |=> refused && req_ready)
    else $error("plain read above 80 MHz not refused");
  code_104_a: assert property (ok && sck_mhz > 8'h5A |=> lat_code == 2'h2)
    else $error("wrong code above 90 MHz");
  out_104_a: assert property (ok && sck_mhz > 8'h5A && sck_mhz <= 8'h68
    && req_cmd == SRLT_RD_QUAD_OUT |=> lat_phase && lat_left == 8'h08)
    else $error("quad out at 104 MHz not 0+8");
  quad_io_104_a: assert property (ok && sck_mhz > 8'h5A && sck_mhz <= 8'h68
    && req_cmd == SRLT_RD_QUAD_IO |=> mode_left == 8'h02 && lat_left == 8'h05)
    else $error("quad I/O at 104 MHz not 2+5");
  fast_133_a: assert property (accept && sck_mhz > 8'h68 && sck_mhz <= 8'h85
    && req_cmd == SRLT_RD_FAST |=> lat_phase && lat_left == 8'h08)
    else $error("fast read at 133 MHz not 0+8");
  other_133_a: assert property (accept && sck_mhz > 8'h68 && req_cmd != SRLT_RD_FAST
    |=> refused && $stable(lat_code))
    else $error("non-fast read above 104 MHz not refused");
  tick_total_a: assert property (data_start |-> tick_cnt == tick_exp && req_ready)
    else $error("inserted cycles differ from row");

  quad_io_cov: cover property (ok && req_cmd == SRLT_RD_QUAD_IO ##[1:40] data_start);
  fast_133_cov: cover property (ok && sck_mhz == 8'h85 ##[1:40] data_start);
  refuse_cov: cover property (refused);
  back_cov: cover property (data_start && ok);

endmodule : srlt_host

// ===== hw/srlt_pkg.sv
// Constants, command kinds and table values for the read latency host.
// Assumes one clock domain; sck frequency is given in whole MHz by logic.
package srlt_pkg;

  // Frequency-limit bytes, which equal the limit in MHz
  localparam logic [7:0] SRLT_LIM_80  = 8'h50;
  localparam logic [7:0] SRLT_LIM_90  = 8'h5A;
  localparam logic [7:0] SRLT_LIM_104 = 8'h68;
  localparam logic [7:0] SRLT_LIM_133 = 8'h85;

  // Latency codes programmed into the flash
  localparam logic [1:0] SRLT_CODE_80  = 2'h0;
  localparam logic [1:0] SRLT_CODE_90  = 2'h1;
  localparam logic [1:0] SRLT_CODE_104 = 2'h2;
  localparam logic [1:0] SRLT_CODE_133 = 2'h2;

  // Mode and latency cycle counts
  localparam logic [7:0] SRLT_CYC_0     = 8'h00;
  localparam logic [7:0] SRLT_CYC_2     = 8'h02;
  localparam logic [7:0] SRLT_CYC_4     = 8'h04;
  localparam logic [7:0] SRLT_CYC_5     = 8'h05;
  localparam logic [7:0] SRLT_CYC_6     = 8'h06;
  localparam logic [7:0] SRLT_CYC_8     = 8'h08;
  localparam logic [7:0] SRLT_CYC_UNSUP = 8'hFF;

  // Read command kinds
  typedef enum logic [2:0] {
    SRLT_RD_PLAIN,
    SRLT_RD_FAST,
    SRLT_RD_DUAL_OUT,
    SRLT_RD_QUAD_OUT,
    SRLT_RD_DUAL_IO,
    SRLT_RD_QUAD_IO
  } srlt_cmd_t;

  // Rows of the table this host uses
  typedef enum logic [2:0] {
    SRLT_ROW_80,
    SRLT_ROW_90,
    SRLT_ROW_104,
    SRLT_ROW_133,
    SRLT_ROW_NONE
  } srlt_row_t;

endpackage : srlt_pkg

// ===== hw/srlt_row_lookup.sv
// Combinational lookup of row, latency code and cycle counts.
// Assumes sck_mhz and cmd are stable logic signals on the caller's clock.
`timescale 1ns/1ps
module srlt_row_lookup
  import srlt_pkg::*;
(
  input  wire logic [7:0] sck_mhz,     // Serial clock rate in MHz
  input  wire srlt_cmd_t  cmd,         // Read command kind
  output srlt_row_t       row,         // Chosen row
  output logic      [1:0] code,        // Latency code of that row
  output logic      [7:0] mode_cyc,    // Mode cycles, FFh if unsupported
  output logic      [7:0] lat_cyc,     // Latency cycles, FFh if unsupported
  output logic            supported    // Command usable at this rate
);

  function automatic srlt_row_t pick_row(input logic [7:0] mhz);
    if (mhz <= SRLT_LIM_80)       pick_row = SRLT_ROW_80;
    else if (mhz <= SRLT_LIM_90)  pick_row = SRLT_ROW_90;
    else if (mhz <= SRLT_LIM_104) pick_row = SRLT_ROW_104;
    else if (mhz <= SRLT_LIM_133) pick_row = SRLT_ROW_133;
    else                          pick_row = SRLT_ROW_NONE;
  endfunction : pick_row

  // Table entry: {mode, latency} for one row and command
  function automatic logic [15:0] entry(input srlt_row_t r, input srlt_cmd_t c);
    entry = {SRLT_CYC_UNSUP, SRLT_CYC_UNSUP};
    unique case (r)
      SRLT_ROW_80: begin
        unique case (c)
          // plain read only row that allows it
          SRLT_RD_PLAIN:   entry = {SRLT_CYC_0, SRLT_CYC_0};
          SRLT_RD_DUAL_IO: entry = {SRLT_CYC_0, SRLT_CYC_4};
          SRLT_RD_QUAD_IO: entry = {SRLT_CYC_2, SRLT_CYC_4};
          default:         entry = {SRLT_CYC_0, SRLT_CYC_8};
        endcase
      end
      SRLT_ROW_90: begin
        unique case (c)
          SRLT_RD_PLAIN:   entry = {SRLT_CYC_UNSUP, SRLT_CYC_UNSUP};
          SRLT_RD_DUAL_IO: entry = {SRLT_CYC_0, SRLT_CYC_5};
          SRLT_RD_QUAD_IO: entry = {SRLT_CYC_2, SRLT_CYC_4};
          default:         entry = {SRLT_CYC_0, SRLT_CYC_8};
        endcase
      end
      SRLT_ROW_104: begin
        unique case (c)
          SRLT_RD_PLAIN:   entry = {SRLT_CYC_UNSUP, SRLT_CYC_UNSUP};
          SRLT_RD_DUAL_IO: entry = {SRLT_CYC_0, SRLT_CYC_6};
          SRLT_RD_QUAD_IO: entry = {SRLT_CYC_2, SRLT_CYC_5};
          default:         entry = {SRLT_CYC_0, SRLT_CYC_8};
        endcase
      end
      SRLT_ROW_133: begin
        if (c == SRLT_RD_FAST) entry = {SRLT_CYC_0, SRLT_CYC_8};
      end
      default: entry = {SRLT_CYC_UNSUP, SRLT_CYC_UNSUP};
    endcase
  endfunction : entry

  logic [15:0] ent;  // Selected table entry

  // Row, code and counts
  always_comb begin
    row = pick_row(sck_mhz);
    ent = entry(row, cmd);
    unique case (row)
      SRLT_ROW_80:  code = SRLT_CODE_80;
      SRLT_ROW_90:  code = SRLT_CODE_90;
      SRLT_ROW_104: code = SRLT_CODE_104;
      default:      code = SRLT_CODE_133;
    endcase
    mode_cyc  = ent[15:8];
    lat_cyc   = ent[7:0];
    // Unsupported marked by FFh in both fields
    supported = (ent != {SRLT_CYC_UNSUP, SRLT_CYC_UNSUP});
  end

endmodule : srlt_row_lookup

// ===== sim/srlt_flash_model.sv
// Far-side flash model: makes the serial clock ticks and counts dummy cycles.
// Assumes the host's phase outputs on the same clk; the bench clears counts.
`timescale 1ns/1ps
module srlt_flash_model (
  input  wire logic       clk,        // System clock
  input  wire logic       sys_rst,    // Synchronous reset, active high
  input  wire logic [1:0] gap,        // Idle clocks between serial ticks
  input  wire logic       clr,        // Clear the cycle counters
  input  wire logic       mode_phase, // Host drives mode bits
  input  wire logic       lat_phase,  // Dummy latency cycles running
  output logic            sck_tick,   // One pulse per serial clock
  output logic      [7:0] mode_cnt,   // Mode cycles seen
  output logic      [7:0] lat_cnt     // Latency cycles seen
);
  logic       frame; // A read is in its dummy part
  logic [1:0] div;   // Clocks since the last tick

  // Serial clock stands still outside frames
  assign frame    = mode_phase | lat_phase;
  assign sck_tick = frame && (div == gap);

  // Divider restarts each frame, so the first tick timing is repeatable
  always_ff @(posedge clk) begin
    if (sys_rst || !frame || sck_tick) begin
      div <= 2'h0;
    end else begin
      div <= div + 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || clr) begin
      mode_cnt <= 8'h00;
      lat_cnt  <= 8'h00;
    end else if (sck_tick && mode_phase) begin
      mode_cnt <= mode_cnt + 8'h01;
    end else if (sck_tick && lat_phase) begin
      lat_cnt <= lat_cnt + 8'h01;
    end
  end
endmodule : srlt_flash_model

// ===== sim/tb_srlt_host.sv
// Self-checking bench for the read latency host, table rows then hand tests.
// Assumes the flash model in sim/ and the package and host under hw/.
`timescale 1ns/1ps
module tb_srlt_host;
  import srlt_pkg::*;
  typedef struct {
    logic [7:0] mhz;  // Serial clock rate
    srlt_cmd_t  cmd;  // Command kind
    logic       ok;   // Expected to be taken
    logic [1:0] code; // Expected latency code
    logic [7:0] mc;   // Expected mode cycles
    logic [7:0] lc;   // Expected latency cycles
  } srlt_case_t;
  logic clk, sys_rst, sck_tick, req_valid, req_ready, clr;
  logic mode_phase, lat_phase, data_start, refused;
  logic [7:0] sck_mhz, mode_cnt, lat_cnt;
  logic [1:0] lat_code, gap, last_code;
  srlt_cmd_t  req_cmd;
  srlt_case_t rows [$];
  integer bad_count = 0, samples_checked = 0;

  srlt_host dut (.clk(clk), .sys_rst(sys_rst), .sck_mhz(sck_mhz), .sck_tick(sck_tick),
    .req_valid(req_valid), .req_cmd(req_cmd), .req_ready(req_ready), .lat_code(lat_code),
    .mode_phase(mode_phase), .lat_phase(lat_phase), .data_start(data_start),
    .refused(refused));
  srlt_flash_model u_flash (.clk(clk), .sys_rst(sys_rst), .gap(gap), .clr(clr),
    .mode_phase(mode_phase), .lat_phase(lat_phase), .sck_tick(sck_tick),
    .mode_cnt(mode_cnt), .lat_cnt(lat_cnt));

  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic add(input logic [7:0] m, input srlt_cmd_t c, input logic [1:0] k,
                     input logic [7:0] mc, input logic [7:0] lc);
    rows.push_back('{m, c, 1'b1, k, mc, lc});
  endtask : add

  task automatic rej(input logic [7:0] m, input srlt_cmd_t c);
    rows.push_back('{m, c, 1'b0, 2'h0, 8'h00, 8'h00});
  endtask : rej

  // Idle outputs, as after reset
  task automatic idle_check();
    check(req_ready, 1'b1);
    check(lat_code, 2'h0);
    check({mode_phase, lat_phase, data_start, refused}, 4'h0);
  endtask : idle_check

  // One request; entered just after an edge, returns just after an edge
  task automatic run(input srlt_case_t c);
    integer n;
    clr = 1'b1;
    req_valid = 1'b1;
    sck_mhz = c.mhz;
    req_cmd = c.cmd;
    @(posedge clk); #1;
    clr = 1'b0;
    req_valid = 1'b0;
    if (!c.ok) begin
      check(refused, 1'b1);
      check(lat_code, last_code);
      // Refusal pulse lasts one cycle and the host stays idle
      @(posedge clk); #1;
      check(refused, 1'b0);
      check(req_ready, 1'b1);
    end else begin
      check(req_ready, 1'b0);
      check(lat_code, c.code);
      n = 0;
      // Slow ticks need at most 4 clocks per serial cycle
      while (data_start !== 1'b1 && n < 100) begin
        @(posedge clk); #1;
        n++;
      end
      check(data_start, 1'b1);
      check(req_ready, 1'b1);
      check(mode_cnt, c.mc);
      check(lat_cnt, c.lc);
      last_code = c.code;
    end
  endtask : run

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : summarize

  // Watchdog, well past the few hundred clocks the tests need
  initial begin
    #400000;
    bad_count++;
    $display("watchdog expired");
    summarize();
  end

  initial begin
    {sys_rst, req_valid, clr} = 3'h4;
    {sck_mhz, gap, last_code} = 12'h000;
    req_cmd = SRLT_RD_FAST;
    add(8'h50, SRLT_RD_FAST, 2'h0, 8'h00, 8'h08); add(8'h50, SRLT_RD_DUAL_OUT, 2'h0, 8'h00, 8'h08);
    add(8'h50, SRLT_RD_QUAD_OUT, 2'h0, 8'h00, 8'h08); add(8'h50, SRLT_RD_DUAL_IO, 2'h0, 8'h00, 8'h04);
    add(8'h50, SRLT_RD_QUAD_IO, 2'h0, 8'h02, 8'h04);
    add(8'h51, SRLT_RD_DUAL_IO, 2'h1, 8'h00, 8'h05); add(8'h5A, SRLT_RD_FAST, 2'h1, 8'h00, 8'h08);
    add(8'h5A, SRLT_RD_DUAL_OUT, 2'h1, 8'h00, 8'h08); add(8'h5A, SRLT_RD_QUAD_OUT, 2'h1, 8'h00, 8'h08);
    add(8'h5A, SRLT_RD_QUAD_IO, 2'h1, 8'h02, 8'h04); rej(8'h5A, SRLT_RD_PLAIN);
    add(8'h68, SRLT_RD_FAST, 2'h2, 8'h00, 8'h08); add(8'h68, SRLT_RD_DUAL_OUT, 2'h2, 8'h00, 8'h08);
    add(8'h68, SRLT_RD_QUAD_OUT, 2'h2, 8'h00, 8'h08); add(8'h68, SRLT_RD_DUAL_IO, 2'h2, 8'h00, 8'h06);
    add(8'h68, SRLT_RD_QUAD_IO, 2'h2, 8'h02, 8'h05); rej(8'h68, SRLT_RD_PLAIN);
    rej(8'h69, SRLT_RD_DUAL_IO); add(8'h85, SRLT_RD_FAST, 2'h2, 8'h00, 8'h08);
    rej(8'h85, SRLT_RD_DUAL_OUT); rej(8'h85, SRLT_RD_QUAD_OUT); rej(8'h85, SRLT_RD_QUAD_IO);
    rej(8'h85, SRLT_RD_PLAIN); rej(8'h86, SRLT_RD_FAST);
    add(8'h28, SRLT_RD_QUAD_IO, 2'h0, 8'h02, 8'h04);
    repeat (10) @(posedge clk);
    #1;
    idle_check();
    sys_rst = 1'b0;
    // Rows run back to back, tick spacing varied
    foreach (rows[i]) begin
      gap = 2'(i % 3);
      run(rows[i]);
      $display("row %0d done", i);
    end
    // Busy host ignores a request that would be refused
    gap = 2'h3;
    req_valid = 1'b1;
    sck_mhz = 8'h5A;
    req_cmd = SRLT_RD_QUAD_IO;
    @(posedge clk); #1;
    sck_mhz = 8'h86;
    req_cmd = SRLT_RD_PLAIN;
    repeat (3) begin
      check({req_ready, refused, mode_phase, lat_phase}, 4'h2);
      check(lat_code, 2'h1);
      @(posedge clk); #1;
    end
    // Reset in mid-read returns to idle
    {req_valid, sys_rst} = 2'h1;
    @(posedge clk); #1;
    idle_check();
    sys_rst = 1'b0;
    last_code = 2'h0;
    run(rows[4]);
    $display("busy and reset test done");
    summarize();
  end
endmodule : tb_srlt_host
